/* pbm_registers.sv */
// Management register bank of a 10/100 transceiver behind the serial management pins
`include "pbm_consts.svh"

module pbm_registers
  import pbm_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PBM_PHY_ADDR_DEFAULT
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe,
  input  wire logic speed_strap,
  input  wire logic autoneg_strap_input,
  input  wire logic isolate_strap,
  input  wire logic duplex_strap,
  input  wire logic an_result_speed_100,
  input  wire logic an_result_full_duplex,
  output logic      soft_reset,
  output logic      an_restart,
  output logic      autoneg_enable,
  output logic      speed_100,
  output logic      full_duplex,
  output logic      loopback,
  output logic      power_down,
  output logic      isolate,
  output logic      col_test,
  output logic      line_tx_enable
);

  // ===================================================================
  // Helpers

  function automatic pbm_ctrl_t pbm_strap_ctrl(input logic [3:0] straps);
    pbm_ctrl_t c;
    c             = '0;
    c.speed_100   = straps[`PBM_STRAP_SPEED];
    c.autoneg_en  = straps[`PBM_STRAP_AUTONEG];
    c.isolate     = straps[`PBM_STRAP_ISOLATE];
    c.full_duplex = ~straps[`PBM_STRAP_DUPLEX];
    return c;
  endfunction

  function automatic logic pbm_implemented(input logic [4:0] idx);
    return (idx <= `PBM_REG_LAST_STANDARD) ||
           (idx == `PBM_REG_INTERFACE_CTRL) ||
           (idx == `PBM_REG_RX_ERROR_COUNT) ||
           (idx == `PBM_REG_IRQ_CTRL_STATUS) ||
           (idx == `PBM_REG_VENDOR_CTRL_A) ||
           (idx == `PBM_REG_VENDOR_CTRL_B);
  endfunction

  function automatic logic [15:0] pbm_read_value(input logic [4:0] idx,
                                                 input pbm_ctrl_t c);
    logic [15:0] v;
    v = 16'h0000;
    if (!pbm_implemented(idx)) begin
      v = 16'h0000;
    end else if (idx == `PBM_REG_BASIC_CONTROL) begin
      v = c;
      v[6:1] = 6'h00;
    end else if (idx == `PBM_REG_BASIC_STATUS) begin
      v = `PBM_BASIC_STATUS_VALUE;
    end
    return v;
  endfunction

  // ===================================================================
  // State

  pbm_state_t st;
  pbm_state_t next_st;
  logic       mdc_rise;
  logic       bit_in;
  pbm_ctrl_t  wr_ctrl;
  logic       wr_commit;

  assign mdc_rise = st.mdc_s2 & ~st.mdc_d;
  assign bit_in   = st.mdio_s2;

  // Write data as it stands on the last data bit
  always_comb begin
    wr_ctrl      = pbm_ctrl_t'({st.shreg[14:0], bit_in});
    wr_ctrl.rsvd = 6'h00;
    wr_commit    = mdc_rise && (st.phase == PBM_WRITE) &&
                   (st.cnt == `PBM_DATA_BITS_LAST) && st.phy_hit &&
                   (st.regad == `PBM_REG_BASIC_CONTROL);
  end

  always_comb begin
    next_st = st;

    // Pin synchronisers
    next_st.mdc_s1   = mdc;
    next_st.mdc_s2   = st.mdc_s1;
    next_st.mdc_d    = st.mdc_s2;
    next_st.mdio_s1  = mdio_in;
    next_st.mdio_s2  = st.mdio_s1;
    next_st.strap_s1 = {speed_strap, autoneg_strap_input, isolate_strap, duplex_strap};
    next_st.strap_s2 = st.strap_s1;

    // Management frame receiver; runs regardless of power down
    if (mdc_rise) begin
      unique case (st.phase)
        PBM_IDLE: begin
          next_st.mdio_oe = 1'b0;
          if (!bit_in) begin
            next_st.phase = PBM_START;
          end
        end
        PBM_START: begin
          next_st.cnt   = 6'h00;
          next_st.phase = bit_in ? PBM_OP : PBM_IDLE;
        end
        PBM_OP: begin
          next_st.shreg = {st.shreg[14:0], bit_in};
          next_st.cnt   = st.cnt + 6'h01;
          if (st.cnt == 6'h01) begin
            next_st.cnt     = 6'h00;
            next_st.op_read = ({st.shreg[0], bit_in} == `PBM_OP_READ);
            if (({st.shreg[0], bit_in} == `PBM_OP_READ) ||
                ({st.shreg[0], bit_in} == `PBM_OP_WRITE)) begin
              next_st.phase = PBM_ADDR;
            end else begin
              next_st.phase = PBM_IDLE;
            end
          end
        end
        PBM_ADDR: begin
          next_st.shreg = {st.shreg[14:0], bit_in};
          next_st.cnt   = st.cnt + 6'h01;
          if (st.cnt == `PBM_ADDR_BITS_LAST) begin
            next_st.cnt     = 6'h00;
            next_st.phy_hit = (st.shreg[8:4] == PHY_ADDR);
            next_st.regad   = {st.shreg[3:0], bit_in};
            next_st.phase   = PBM_TA;
          end
        end
        PBM_TA: begin
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == 6'h00) begin
            // Second turnaround bit: drive zero on a read addressed to us
            next_st.mdio_oe  = st.op_read && st.phy_hit;
            next_st.mdio_out = 1'b0;
          end else begin
            next_st.cnt = 6'h00;
            if (st.op_read) begin
              next_st.shreg    = pbm_read_value(st.regad, st.ctrl);
              next_st.mdio_out = pbm_read_value(st.regad, st.ctrl) >> 15 != 16'h0000;
              next_st.phase    = PBM_READ;
            end else begin
              next_st.phase = PBM_WRITE;
            end
          end
        end
        PBM_READ: begin
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == `PBM_DATA_BITS_LAST) begin
            next_st.mdio_oe  = 1'b0;
            next_st.mdio_out = 1'b0;
            next_st.cnt      = 6'h00;
            next_st.phase    = PBM_IDLE;
          end else begin
            next_st.mdio_out = st.shreg[14];
            next_st.shreg    = {st.shreg[14:0], 1'b0};
          end
        end
        PBM_WRITE: begin
          next_st.shreg = {st.shreg[14:0], bit_in};
          next_st.cnt   = st.cnt + 6'h01;
          if (st.cnt == `PBM_DATA_BITS_LAST) begin
            next_st.cnt   = 6'h00;
            next_st.phase = PBM_IDLE;
          end
        end
      endcase
    end

    // control writes accepted in power down
    if (wr_commit) begin
      next_st.ctrl = wr_ctrl;
    end

    if (st.ctrl.sw_reset) begin
      next_st.ctrl = pbm_strap_ctrl(st.strap_s2);
    end

    if (st.ctrl.an_restart && !wr_commit) begin
      next_st.ctrl.an_restart = 1'b0;
    end

    if (!st.straps_ok) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
      if (st.strap_cnt == `PBM_STRAP_SETTLE) begin
        next_st.straps_ok = 1'b1;
        next_st.ctrl      = pbm_strap_ctrl(st.strap_s2);
      end
    end

    next_st.eff_speed_100   = st.ctrl.autoneg_en ? an_result_speed_100 : st.ctrl.speed_100;
    next_st.eff_full_duplex = st.ctrl.autoneg_en ? an_result_full_duplex
                                                 : st.ctrl.full_duplex;
    // line transmitter gating; held off until the isolate strap is loaded
    next_st.line_tx_enable = st.straps_ok & ~st.ctrl.tx_disable & ~st.ctrl.isolate &
                             ~st.ctrl.power_down;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ===================================================================
  // Outputs

  assign mdio_out       = st.mdio_out;
  assign mdio_oe        = st.mdio_oe;
  assign soft_reset     = st.ctrl.sw_reset;
  assign an_restart     = st.ctrl.an_restart;
  assign autoneg_enable = st.ctrl.autoneg_en;
  assign speed_100      = st.eff_speed_100;
  assign full_duplex    = st.eff_full_duplex;
  assign loopback       = st.ctrl.loopback;
  assign power_down     = st.ctrl.power_down;
  assign isolate        = st.ctrl.isolate;
  assign col_test       = st.ctrl.col_test;
  assign line_tx_enable = st.line_tx_enable;

  // ===================================================================
  // Assertions

  a_sw_reset_clear: assert property (@(posedge clk) disable iff (!nrst)
    st.ctrl.sw_reset |=> !st.ctrl.sw_reset &&
      (st.ctrl == pbm_strap_ctrl($past(st.strap_s2))))
    else $error("software reset bit did not clear to strap defaults");

  a_restart_clear: assert property (@(posedge clk) disable iff (!nrst)
    (st.ctrl.an_restart && !wr_commit) |=> !st.ctrl.an_restart)
    else $error("restart bit did not clear itself");

  a_speed_select: assert property (@(posedge clk) disable iff (!nrst)
    st.straps_ok |=> speed_100 ==
      ($past(st.ctrl.autoneg_en) ? $past(an_result_speed_100) : $past(st.ctrl.speed_100)))
    else $error("effective speed wrong");

  a_duplex_select: assert property (@(posedge clk) disable iff (!nrst)
    (st.straps_ok && st.ctrl.autoneg_en) |=> full_duplex == $past(an_result_full_duplex))
    else $error("negotiated duplex not applied");

  a_strap_load: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.straps_ok) |-> st.ctrl.speed_100 == $past(st.strap_s2[`PBM_STRAP_SPEED]) &&
      st.ctrl.autoneg_en == $past(st.strap_s2[`PBM_STRAP_AUTONEG]) &&
      st.ctrl.isolate == $past(st.strap_s2[`PBM_STRAP_ISOLATE]))
    else $error("strap defaults not loaded");

  a_duplex_strap: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.straps_ok) |-> st.ctrl.full_duplex == !$past(st.strap_s2[`PBM_STRAP_DUPLEX]))
    else $error("duplex default not inverse of strap");

  a_tx_col_default: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.straps_ok) |-> (!st.ctrl.tx_disable && !st.ctrl.col_test && !line_tx_enable)
      ##1 (line_tx_enable == !$past(st.ctrl.isolate)))
    else $error("transmitter or collision test default wrong");

  a_col_test_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit |=> col_test == $past(st.shreg[6]) || $past(st.ctrl.sw_reset))
    else $error("collision test bit not written");

  a_isolate_tx: assert property (@(posedge clk) disable iff (!nrst)
    (isolate || st.ctrl.tx_disable) |=> !line_tx_enable)
    else $error("line transmitter active while isolated or disabled");

  a_status_ability: assert property (@(posedge clk) disable iff (!nrst)
    (mdc_rise && st.phase == PBM_TA && st.cnt == 6'h01 && st.op_read &&
     st.regad == `PBM_REG_BASIC_STATUS) |=>
      st.shreg[`PBM_STATUS_ABILITY_MSB:`PBM_STATUS_ABILITY_LSB] == `PBM_STATUS_ABILITY &&
      !mdio_out)
    else $error("status ability bits wrong");

  a_reserved_read: assert property (@(posedge clk) disable iff (!nrst)
    (st.phase == PBM_READ && !pbm_implemented(st.regad)) |-> !mdio_out)
    else $error("reserved register read nonzero");

  a_power_down_access: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && power_down) |=> power_down == $past(st.shreg[10]) ||
      $past(st.ctrl.sw_reset))
    else $error("control write refused in power down");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    st.ctrl.rsvd == 6'h00)
    else $error("reserved control bits nonzero");

  a_reset_pulse: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset |=> !soft_reset)
    else $error("software reset output longer than one clock");

  a_restart_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit |=> an_restart == $past(st.shreg[8]) || $past(st.ctrl.sw_reset))
    else $error("restart bit not written");

  a_tx_enable: assert property (@(posedge clk) disable iff (!nrst)
    (st.straps_ok && !st.ctrl.tx_disable && !isolate && !power_down) |=> line_tx_enable)
    else $error("line transmitter not enabled");

  a_power_down_tx: assert property (@(posedge clk) disable iff (!nrst)
    power_down |=> !line_tx_enable)
    else $error("line transmitter active in power down");

  a_read_drive: assert property (@(posedge clk) disable iff (!nrst)
    (st.phase == PBM_READ && st.op_read && st.phy_hit) |-> mdio_oe)
    else $error("read data not driven");

  a_foreign_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !st.phy_hit |-> !mdio_oe)
    else $error("data pin driven for a foreign address");

  a_col_reset: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset |=> !col_test)
    else $error("collision test not cleared by software reset");

endmodule // pbm_registers

/* pbm_consts.svh */
// Register indices, bit positions and fixed values of the management register bank
`ifndef PBM_CONSTS_SVH
`define PBM_CONSTS_SVH

// =====================================================================
// Register indices
`define PBM_REG_BASIC_CONTROL    5'h00
`define PBM_REG_BASIC_STATUS     5'h01
`define PBM_REG_LAST_STANDARD    5'h08
`define PBM_REG_INTERFACE_CTRL   5'h14
`define PBM_REG_RX_ERROR_COUNT   5'h15
`define PBM_REG_IRQ_CTRL_STATUS  5'h1b
`define PBM_REG_VENDOR_CTRL_A    5'h1e
`define PBM_REG_VENDOR_CTRL_B    5'h1f

// =====================================================================
// Basic status read value: capability bits and other fixed bits
`define PBM_BASIC_STATUS_VALUE   16'h7849
`define PBM_STATUS_ABILITY_MSB   15
`define PBM_STATUS_ABILITY_LSB   12
`define PBM_STATUS_ABILITY       4'h7

// =====================================================================
// Management frame
`define PBM_PHY_ADDR_DEFAULT     5'h01
`define PBM_OP_READ              2'h2
`define PBM_OP_WRITE             2'h1
`define PBM_ADDR_BITS_LAST       6'h09
`define PBM_DATA_BITS_LAST       6'h0f
`define PBM_TA_BITS_LAST         6'h01

// =====================================================================
// Strap vector layout and settle time after reset release
`define PBM_STRAP_SPEED          3
`define PBM_STRAP_AUTONEG        2
`define PBM_STRAP_ISOLATE        1
`define PBM_STRAP_DUPLEX         0
`define PBM_STRAP_SETTLE         2'h2

`endif

/* pbm_pkg.sv */
// Types of the management register bank
package pbm_pkg;

  typedef enum logic [2:0] {
    PBM_IDLE,
    PBM_START,
    PBM_OP,
    PBM_ADDR,
    PBM_TA,
    PBM_READ,
    PBM_WRITE
  } pbm_phase_t;

  // Basic control register, bit 15 first
  typedef struct packed {
    logic       sw_reset;
    logic       loopback;
    logic       speed_100;
    logic       autoneg_en;
    logic       power_down;
    logic       isolate;
    logic       an_restart;
    logic       full_duplex;
    logic       col_test;
    logic [5:0] rsvd;
    logic       tx_disable;
  } pbm_ctrl_t;

  typedef struct packed {
    logic       mdc_s1;
    logic       mdc_s2;
    logic       mdc_d;
    logic       mdio_s1;
    logic       mdio_s2;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [1:0] strap_cnt;
    logic       straps_ok;
    pbm_phase_t phase;
    logic [5:0] cnt;
    logic       op_read;
    logic       phy_hit;
    logic [4:0] regad;
    logic [15:0] shreg;
    logic       mdio_out;
    logic       mdio_oe;
    pbm_ctrl_t  ctrl;
    logic       eff_speed_100;
    logic       eff_full_duplex;
    logic       line_tx_enable;
  } pbm_state_t;

endpackage

/* pbm_station.sv */
// Station model that drives the serial management clock and data pins
`include "pbm_consts.svh"

module pbm_station
  import pbm_pkg::*;
(
  input  wire logic clk,
  input  wire logic line,
  output logic      mdc,
  output logic      drv_oe,
  output logic      drv_bit
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_bit = 1'b1;
  end

  // ======
  // One bit period: drive in the low half, sample just before the rise
  task automatic bit_cyc(input logic oe, input logic b, output logic seen);
    @(posedge clk);
    #1;
    mdc = 1'b0;
    drv_oe = oe;
    drv_bit = b;
    repeat (8) @(posedge clk);
    #1;
    seen = line;
    mdc = 1'b1;
    repeat (7) @(posedge clk);
  endtask

  // ======
  // Whole frame; the clock stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [13:0] h;
    logic        s;
    logic        w;
    h = {2'b01, op, phy, ra};
    w = (op == `PBM_OP_WRITE);
    rd = 16'h0000;
    for (int i = 0; i < 4; i++)
      bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      bit_cyc(1'b1, h[i], s);
    bit_cyc(w, 1'b1, s);
    bit_cyc(w, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(w, wd[i], s);
      rd[i] = s;
    end
    bit_cyc(1'b0, 1'b1, s);
    @(posedge clk);
    #1;
    mdc = 1'b0;
  endtask
endmodule // pbm_station

/* testbench.sv */
// Self-checking bench of the management register bank
`include "pbm_consts.svh"

module testbench
  import pbm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        mdc, mdio_out, mdio_oe, drv_oe, drv_bit;
  logic [3:0]  strap = 4'b1011;
  logic [1:0]  an_res = 2'b10;
  logic        soft_reset, an_restart, autoneg_enable, speed_100, full_duplex;
  logic        loopback, power_down, isolate, col_test, line_tx_enable;
  logic [15:0] rd;
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_sr = 0;
  int          n_ar = 0;
  // Pull-up holds the data line high when nobody drives it
  wire logic   mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_bit : 1'b1);
  wire logic [7:0] outs = {autoneg_enable, speed_100, full_duplex, loopback,
                           power_down, isolate, col_test, line_tx_enable};

  always #50 clk = ~clk;

  pbm_registers pbm_registers_i (
    .clk, .nrst, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .speed_strap(strap[3]), .autoneg_strap_input(strap[2]),
    .isolate_strap(strap[1]), .duplex_strap(strap[0]),
    .an_result_speed_100(an_res[1]), .an_result_full_duplex(an_res[0]),
    .soft_reset, .an_restart, .autoneg_enable, .speed_100, .full_duplex,
    .loopback, .power_down, .isolate, .col_test, .line_tx_enable
  );
  pbm_station pbm_station_i (.clk, .line(mdio_in), .mdc, .drv_oe, .drv_bit);

  // Pulses are counted where the outputs have settled
  always @(negedge clk) begin
    if (soft_reset === 1'b1)
      n_sr++;
    if (an_restart === 1'b1)
      n_ar++;
  end

  // ======
  // Access and compare tasks
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    pbm_station_i.xfer(`PBM_OP_WRITE, `PBM_PHY_ADDR_DEFAULT, ra, d, x);
  endtask

  task automatic rdr(input logic [4:0] ra);
    pbm_station_i.xfer(`PBM_OP_READ, `PBM_PHY_ADDR_DEFAULT, ra, 16'h0000, rd);
  endtask

  task automatic chk_out(input logic [7:0] exp);
    check("mode outputs", {8'h00, outs}, {8'h00, exp});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #5_000_000;
    n_errors++;
    summarize();
  end

  // ======
  // Test sequence; output bits: an, spd, fdx, lpb, pdn, iso, col, txen
  initial begin
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk_out(8'h44);
    rdr(5'h00);
    check("control after reset", rd, 16'h2400);
    rdr(5'h01);
    check("ability bits", {12'h000, rd[15:12]}, 16'h0007);
    wr(5'h00, 16'h01fe);
    chk_out(8'h23);
    rdr(5'h00);
    check("reserved control bits", rd, 16'h0180);
    an_res = 2'b01;
    wr(5'h00, 16'h3001);
    chk_out(8'ha0);
    an_res = 2'b10;
    repeat (4) @(posedge clk);
    #1;
    chk_out(8'hc0);
    n_ar = 0;
    wr(5'h00, 16'h3201);
    check("restart pulses", n_ar[15:0], 16'h0001);
    rdr(5'h00);
    check("restart self clear", rd, 16'h3001);
    wr(5'h00, 16'h4800);
    chk_out(8'h18);
    rdr(5'h00);
    check("access in power down", rd, 16'h4800);
    for (int a = 9; a < 30; a++)
      if (a < 6'h14 || (a > 6'h15 && a < 6'h1b) || a > 6'h1b) begin
        rdr(a[4:0]);
        check("reserved index", rd, 16'h0000);
      end
    // Foreign station address: no write lands, the pull-up shows on reads
    pbm_station_i.xfer(`PBM_OP_WRITE, 5'h02, 5'h00, 16'h0000, rd);
    pbm_station_i.xfer(`PBM_OP_READ, 5'h02, 5'h00, 16'h0000, rd);
    check("foreign address read", rd, 16'hffff);
    wr(5'h04, 16'h0000);
    rdr(5'h00);
    check("write decode", rd, 16'h4800);
    strap = 4'b0100;
    repeat (8) @(posedge clk);
    #1;
    n_sr = 0;
    wr(5'h00, 16'h8000);
    check("soft reset pulses", n_sr[15:0], 16'h0001);
    chk_out(8'hc1);
    rdr(5'h00);
    check("control after soft reset", rd, 16'h1100);
    nrst = 1'b0;
    @(posedge clk);
    #1;
    chk_out(8'h00);
    nrst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk_out(8'hc1);
    summarize();
  end
endmodule // testbench
